// ### design/sdsr_burst_counter.sv
// Two-bit burst address counter with linear or interleaved order.
// Assumes load is already qualified by select and sleep, and step by sleep.
`default_nettype none

module sdsr_burst_counter (
   // Clock and reset
   input  wire logic      i_sys_clk,
   input  wire logic      i_rst,
   // Counter controls
   sdsr_burst_if.ctr      bus
);

   logic [1:0]            start;   // Offset loaded at burst start
   logic [1:0]            count;   // Beats stepped so far
   sdsr_pkg::sdsr_burst_e state;   // Set by the first load, held until reset

   // Start offset and beat count
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         start <= 2'h0;
         count <= 2'h0;
      end else if (bus.load) begin
         start <= bus.preset;                    // R18
         count <= 2'h0;                          // R3
      end else if (bus.step && state == sdsr_pkg::BURST_ACTIVE) begin
         count <= count + sdsr_pkg::CNT_ONE;     // R4 R5
      end
   end

   // Burst state follows the first load
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state <= sdsr_pkg::BURST_IDLE;
      end else begin
         case (state)
            sdsr_pkg::BURST_IDLE:   if (bus.load) begin
               state <= sdsr_pkg::BURST_ACTIVE;
            end
            sdsr_pkg::BURST_ACTIVE: state <= sdsr_pkg::BURST_ACTIVE;
            default:                state <= sdsr_pkg::BURST_IDLE;
         endcase
      end
   end

   // Order applied to the count; wraps after four beats
   assign bus.offset = sdsr_pkg::burst_offset(start, count, bus.linear); // R6 R22
   assign bus.active = (state == sdsr_pkg::BURST_ACTIVE);

endmodule

`default_nettype wire

// ### design/sdsr_burst_if.sv
// Carries burst counter controls between the top and the counter.
// Assumes both ends run on the same system clock.
`default_nettype none

interface sdsr_burst_if;
   logic       load;      // Load a new start offset
   logic       step;      // Advance the burst by one beat
   logic [1:0] preset;    // Start offset from the low address bits
   logic       linear;    // Linear order when high, interleaved when low
   logic [1:0] offset;    // Current low address of the burst
   logic       active;    // A burst has been started since reset

   // Top side drives controls and reads the offset
   modport ctl (output load, output step, output preset, output linear,
                input offset, input active);
   // Counter side
   modport ctr (input load, input step, input preset, input linear,
                output offset, output active);
endinterface

`default_nettype wire

// ### design/sdsr_output_stage.sv
// Read output register, flow-through bypass and output drive control.
// Assumes read data settles within the cycle after the access is captured.
`default_nettype none

module sdsr_output_stage #(
   parameter int DATA_W = sdsr_pkg::W_X36
) (
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Static modes
   input  wire logic              i_flow_through_select,
   input  wire logic              i_deselect_mode_select,
   // Asynchronous controls
   input  wire logic              i_out_enable_n,
   input  wire logic              i_sleep_request,
   // Captured access
   input  wire logic              i_read,
   input  wire logic              i_deselect,
   input  wire logic [DATA_W-1:0] i_read_data,
   // Data pins
   output logic      [DATA_W-1:0] o_dq,
   output logic                   o_dq_oe_n
);

   logic [DATA_W-1:0] data_q;   // Output register
   logic              read_q;   // Read held in the output stage
   logic              flow;     // Flow-through mode
   logic              drive;    // Synchronous drive request

   assign flow = (i_flow_through_select == sdsr_pkg::FLOW_THROUGH_LEVEL);

   // Output register loads on every captured read
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         data_q <= '0;
      end else if (i_read) begin
         data_q <= i_read_data;                  // R9
      end
   end

   // Read flag one stage behind the input registers
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         read_q <= 1'h0;
      end else begin
         read_q <= i_read;                       // R10
      end
   end

   // Drive timing per output and deselect mode
   always_comb begin
      if (flow) begin
         drive = i_read;
      end else if (i_deselect_mode_select == sdsr_pkg::SINGLE_DESEL_LEVEL) begin
         drive = read_q && !i_deselect;          // R11 R12
      end else begin
         drive = read_q;                         // R10 R12
      end
   end

   // Bypass in flow-through mode
   assign o_dq      = flow ? i_read_data : data_q;               // R8 R9
   // Enable and sleep gate the drivers without the clock
   assign o_dq_oe_n = !(drive && !i_out_enable_n && !i_sleep_request); // R2 R24

endmodule

`default_nettype wire

// ### design/sdsr_pkg.sv
// Shared constants for the synchronous burst static memory block.
// Assumes a single system clock; every user of it writes sdsr_pkg::name.
`default_nettype none

package sdsr_pkg;

   // Data lane geometry: one lane is eight data bits plus one parity bit
   localparam int LANE_BITS   = 9;
   localparam int W_X18       = 18;
   localparam int W_X36       = 36;
   localparam int W_X72       = 72;

   // Word counts of the three organisations
   localparam int DEPTH_X18   = 2097152;
   localparam int DEPTH_X36   = 1048576;
   localparam int DEPTH_X72   = 524288;

   // Address widths that match the word counts above
   localparam int AW_X18      = 21;
   localparam int AW_X36      = 20;
   localparam int AW_X72      = 19;

   // Burst counter: two bits, four beats before the wrap
   localparam int CNT_W       = 2;
   localparam int BURST_LEN   = 4;
   localparam logic [1:0] CNT_ONE = 2'h1;

   // Levels that the mode inputs take when left floating
   localparam logic DEFAULT_FLOW_THROUGH_SELECT  = 1'h1; // Pipelined output
   localparam logic DEFAULT_BURST_ORDER_SELECT   = 1'h1; // Interleaved order
   localparam logic DEFAULT_DESELECT_MODE_SELECT = 1'h1; // Single-cycle deselect

   // Mode input levels
   localparam logic FLOW_THROUGH_LEVEL = 1'h0;  // Low bypasses output register
   localparam logic LINEAR_ORDER_LEVEL = 1'h0;  // Low selects linear order
   localparam logic SINGLE_DESEL_LEVEL = 1'h1;  // High selects single-cycle deselect

   // Burst sequencing state
   typedef enum logic [0:0] {
      BURST_IDLE,
      BURST_ACTIVE
   } sdsr_burst_e;

   // Address width for a given data width
   function automatic int addr_w(input int dw);
      if (dw == W_X18) begin
         return AW_X18;
      end else if (dw == W_X72) begin
         return AW_X72;
      end else begin
         return AW_X36;
      end
   endfunction

   // Current two-bit offset of a burst in either order
   function automatic logic [1:0] burst_offset(input logic [1:0] start,
                                               input logic [1:0] count,
                                               input logic       linear);
      if (linear) begin
         return start + count;
      end else begin
         return start ^ count;
      end
   endfunction

endpackage

`default_nettype wire

// ### design/sdsr_sync_burst_sram.sv
// Synchronous burst static memory: input registers, burst control, array.
// Assumes host strobes and controls are active low and change after the edge.
`default_nettype none
// What this block does
// R1: Synchronous inputs sampled only on rising edge
// R2: Output enable and sleep act asynchronously
// R3: Either address strobe starts burst, loads counter
// R4: Burst steps only when advance sampled
// R5: Two-bit counter, four beats then wrap
// R6: Order input picks linear or interleaved
// R7: New address accepted every cycle
// R8: Flow-through low bypasses output register
// R9: Pipeline high registers read data
// R10: Dual deselect pipelined like reads
// R11: Single deselect turns off one stage earlier
// R12: Mode input selects single or dual deselect
// R13: Byte write enable writes selected lanes
// R14: Global write writes all lanes
// R15: Writes self-timed from registered command
// R16: Floating modes default single, interleaved, pipelined
// R17: Width 18, 36 or 72 bits
// R18: Low address bits preset burst counter
// R19: Host drives strobes low to assert
// R20: Host drives advance low to step
// R21: Selected when enables low, high, low
// R22: Linear adds one; interleaved XORs count
// R23: Pipelined bursts 3-1-1-1, flow-through 2-1-1-1
// R24: Sleep ignores commands, disables outputs

module sdsr_sync_burst_sram #(
   parameter int DATA_W = sdsr_pkg::W_X36,                      // R17
   parameter int LANES  = DATA_W / sdsr_pkg::LANE_BITS,
   parameter int ADDR_W = sdsr_pkg::addr_w(DATA_W)
) (
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Address and data
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_dq,
   output logic      [DATA_W-1:0] o_dq,
   output logic                   o_dq_oe_n,
   // Chip enables
   input  wire logic              i_chip_enable_first_n,
   input  wire logic              i_chip_enable_second,
   input  wire logic              i_chip_enable_third_n,
   // Burst controls
   input  wire logic              i_proc_addr_strobe_n,
   input  wire logic              i_ctrl_addr_strobe_n,
   input  wire logic              i_burst_advance_n,
   // Write controls
   input  wire logic              i_global_write_n,
   input  wire logic              i_byte_write_enable_n,
   input  wire logic [LANES-1:0]  i_lane_byte_select_n,
   // Asynchronous controls
   input  wire logic              i_out_enable_n,
   input  wire logic              i_sleep_request,
   // Static modes
   input  wire logic              i_flow_through_select,
   input  wire logic              i_burst_order_select,
   input  wire logic              i_deselect_mode_select
);

   localparam int DEPTH = 2 ** ADDR_W;

   // Memory array
   logic [DATA_W-1:0]        mem [DEPTH];

   // Decoded inputs of this cycle
   logic                     selected;     // All three enables true
   logic                     strobe;       // Either address strobe low
   logic                     proc_strobe;  // Processor strobe low
   logic                     start;        // New address taken
   logic                     deselect;     // Strobe while not selected
   logic                     cont;         // Burst continue cycle
   logic                     wr_any;       // Write with at least one lane selected
   logic [LANES-1:0]         lane_mask;    // Lanes to write
   logic                     wr_cmd;       // Write taken this cycle

   // Input registers
   logic [ADDR_W-1:2]        addr_hi;      // Upper address of the burst
   logic                     acc_valid;    // Access captured
   logic                     acc_write;    // Captured access writes
   logic                     acc_desel;    // Deselect captured
   logic [DATA_W-1:0]        wr_data;      // Captured write data
   logic [LANES-1:0]         wr_mask;      // Captured lane mask

   // Access address and read path
   logic [ADDR_W-1:0]        acc_addr;     // Word addressed this cycle
   logic [DATA_W-1:0]        rd_data;      // Array read
   logic [DATA_W-1:0]        bit_mask;     // Lane mask spread to bits

   sdsr_burst_if burst ();

   // Chip select decode
   assign selected    = !i_chip_enable_first_n && i_chip_enable_second
                        && !i_chip_enable_third_n;                // R21
   // Strobes are active low
   assign proc_strobe = !i_proc_addr_strobe_n;                    // R19
   assign strobe      = proc_strobe || !i_ctrl_addr_strobe_n;     // R19
   // Sleep masks every command
   assign start       = strobe && selected && !i_sleep_request;   // R3 R7 R24
   assign deselect    = strobe && !selected && !i_sleep_request;
   assign cont        = !strobe && burst.active && !acc_desel && !i_sleep_request;
   // Processor-strobe starts are always reads
   assign wr_cmd      = wr_any && !(start && proc_strobe) && (start || cont);

   // Counter controls
   assign burst.load   = start;                                   // R3
   assign burst.step   = cont && !i_burst_advance_n;              // R4 R20
   assign burst.preset = i_addr[1:0];                             // R18
   assign burst.linear = (i_burst_order_select == sdsr_pkg::LINEAR_ORDER_LEVEL); // R6

   // Burst address counter
   sdsr_burst_counter u_counter (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .bus       (burst)
   );

   // Write lane decode
   sdsr_write_lanes #(
      .LANES (LANES)
   ) u_lanes (
      .i_global_write_n      (i_global_write_n),
      .i_byte_write_enable_n (i_byte_write_enable_n),
      .i_lane_byte_select_n  (i_lane_byte_select_n),
      .o_lane_mask           (lane_mask),
      .o_write               (wr_any)
   );

   // Upper address captured on a burst start
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         addr_hi <= '0;
      end else if (start) begin
         addr_hi <= i_addr[ADDR_W-1:2];          // R1 R7
      end
   end

   // Access flags captured every edge
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         acc_valid <= 1'h0;
         acc_write <= 1'h0;
         acc_desel <= 1'h0;
      end else begin
         acc_valid <= start || cont;             // R1
         acc_write <= wr_cmd;
         acc_desel <= deselect || (acc_desel && !start);
      end
   end

   // Write data and lanes captured with the command
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         wr_data <= '0;
         wr_mask <= '0;
      end else if (wr_cmd) begin
         wr_data <= i_dq;                        // R1
         wr_mask <= lane_mask;
      end
   end

   // Addressed word: burst offset in the low bits
   assign acc_addr = {addr_hi, burst.offset};    // R18
   assign bit_mask = sdsr_pkg::burst_offset(2'h0, 2'h0, 1'h1) == 2'h0 ?
                     spread(wr_mask) : '0;
   assign rd_data  = mem[acc_addr];

   // Lane mask spread across nine-bit lanes
   function automatic logic [DATA_W-1:0] spread(input logic [LANES-1:0] m);
      logic [DATA_W-1:0] b;
      b = '0;
      for (int i = 0; i < LANES; i++) begin
         b[i*sdsr_pkg::LANE_BITS +: sdsr_pkg::LANE_BITS] =
            {sdsr_pkg::LANE_BITS{m[i]}};
      end
      return b;
   endfunction

   // Self-timed write of the captured word
   always_ff @(posedge i_sys_clk) begin
      if (acc_valid && acc_write) begin
         mem[acc_addr] <= (mem[acc_addr] & ~bit_mask) | (wr_data & bit_mask); // R15 R13 R14
      end
   end

   // Output register, bypass and drive timing
   sdsr_output_stage #(
      .DATA_W (DATA_W)
   ) u_out (
      .i_sys_clk              (i_sys_clk),
      .i_rst                  (i_rst),
      .i_flow_through_select  (i_flow_through_select),
      .i_deselect_mode_select (i_deselect_mode_select),
      .i_out_enable_n         (i_out_enable_n),
      .i_sleep_request        (i_sleep_request),
      .i_read                 (acc_valid && !acc_write),  // R23
      .i_deselect             (acc_desel),                // R11
      .i_read_data            (rd_data),
      .o_dq                   (o_dq),
      .o_dq_oe_n              (o_dq_oe_n)
   );

endmodule

// Write lane decode: global write covers all lanes
module sdsr_write_lanes #(
   parameter int LANES = 4
) (
   // Write controls, active low
   input  wire logic             i_global_write_n,
   input  wire logic             i_byte_write_enable_n,
   input  wire logic [LANES-1:0] i_lane_byte_select_n,
   // Decoded write
   output logic      [LANES-1:0] o_lane_mask,
   output logic                  o_write
);

   // Global write overrides byte controls
   always_comb begin
      if (!i_global_write_n) begin
         o_lane_mask = '1;                       // R14
      end else if (!i_byte_write_enable_n) begin
         o_lane_mask = ~i_lane_byte_select_n;    // R13
      end else begin
         o_lane_mask = '0;
      end
   end

   assign o_write = |o_lane_mask;

endmodule

`default_nettype wire

// ### verif/sdsr_host_model.sv
// Bus master model issuing one command per clock to the memory.
// Assumes op is called right after a rising edge.
`default_nettype none

module sdsr_host_model #(
   parameter int DATA_W = 36,
   parameter int LANES  = 4,
   parameter int ADDR_W = 20
) (
   // Clock
   input  wire logic              i_sys_clk,
   // Bus toward the memory
   output logic      [ADDR_W-1:0] o_addr,
   output logic      [DATA_W-1:0] o_dq,
   output logic                   o_chip_enable_first_n,
   output logic                   o_chip_enable_second,
   output logic                   o_chip_enable_third_n,
   output logic                   o_proc_addr_strobe_n,
   output logic                   o_ctrl_addr_strobe_n,
   output logic                   o_burst_advance_n,
   output logic                   o_global_write_n,
   output logic                   o_byte_write_enable_n,
   output logic      [LANES-1:0]  o_lane_byte_select_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      o_addr = '0;
      o_dq = '0;
      o_chip_enable_first_n = 1'b0;
      o_chip_enable_second = 1'b1;
      o_chip_enable_third_n = 1'b0;
      o_proc_addr_strobe_n = 1'b1;
      o_ctrl_addr_strobe_n = 1'b1;
      o_burst_advance_n = 1'b1;
      o_global_write_n = 1'b1;
      o_byte_write_enable_n = 1'b1;
      o_lane_byte_select_n = '1;
   end
   // One bus cycle, held until the next edge
   task automatic op(input int k, input logic [ADDR_W-1:0] a = '0,
                     input logic [DATA_W-1:0] d = '0, input logic [LANES-1:0] ls_n = '1);
      o_addr <= a;
      o_dq <= (k inside {3, 4, 6, 8}) ? d : ~o_dq; // Released data toggles
      o_chip_enable_first_n <= (k == 7);
      o_proc_addr_strobe_n <= !(k inside {1, 8});
      o_ctrl_addr_strobe_n <= !(k inside {2, 3, 4, 7});
      o_burst_advance_n <= !(k inside {5, 6});
      o_global_write_n <= !(k inside {3, 6, 8});
      o_byte_write_enable_n <= (k != 4);
      o_lane_byte_select_n <= ls_n;
      @(posedge i_sys_clk);
   endtask
endmodule

`default_nettype wire

// ### verif/sdsr_sync_burst_sram_props.sv
// Pin-level timing checks on the output drive of the burst memory.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none

module sdsr_sync_burst_sram_props #(
   parameter int LANES = 4
) (
   // Clock and reset
   input wire logic             i_sys_clk,
   input wire logic             i_rst,
   // Watched pins
   input wire logic             o_dq_oe_n,
   input wire logic             i_chip_enable_first_n,
   input wire logic             i_chip_enable_second,
   input wire logic             i_chip_enable_third_n,
   input wire logic             i_proc_addr_strobe_n,
   input wire logic             i_ctrl_addr_strobe_n,
   input wire logic             i_global_write_n,
   input wire logic             i_byte_write_enable_n,
   input wire logic [LANES-1:0] i_lane_byte_select_n,
   input wire logic             i_out_enable_n,
   input wire logic             i_sleep_request,
   input wire logic             i_flow_through_select,
   input wire logic             i_deselect_mode_select
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Decoded commands at an edge
   logic sel, stb, go, wr, rd, dsl, off;
   assign sel = !i_chip_enable_first_n && i_chip_enable_second && !i_chip_enable_third_n;
   assign stb = !i_proc_addr_strobe_n || !i_ctrl_addr_strobe_n;
   assign go  = sel && stb && !i_sleep_request;
   assign wr  = go && i_proc_addr_strobe_n &&
                (!i_global_write_n || (!i_byte_write_enable_n && !(&i_lane_byte_select_n)));
   assign rd  = go && !wr;
   assign dsl = stb && !sel && !i_sleep_request;
   assign off = i_out_enable_n || i_sleep_request;
   // Deselect followed by two idle cycles
   sequence s_desel_quiet;
      dsl ##1 !go ##1 !go;
   endsequence
   // Pipelined read not cut by a deselect
   sequence s_read_held;
      rd && i_flow_through_select ##1 !dsl && !i_sleep_request;
   endsequence
   a_async_off: assert property (off |-> o_dq_oe_n)
      else $error("drive on while disabled");
   a_pipe_late: assert property (
      rd && i_flow_through_select && o_dq_oe_n && !off &&
      $past(stb || !i_global_write_n) && !$past(rd) |=> o_dq_oe_n)
      else $error("pipelined read drove too early");
   a_pipe_on: assert property (s_read_held |=> off || !o_dq_oe_n)
      else $error("pipelined read not driven");
   a_flow_on: assert property (
      rd && !i_flow_through_select && !$past(dsl) |=> off || !o_dq_oe_n)
      else $error("flow-through read not driven");
   a_single_desel: assert property (dsl && i_deselect_mode_select |=> o_dq_oe_n)
      else $error("single deselect left drive on");
   a_dual_hold: assert property (
      dsl && !i_deselect_mode_select && i_flow_through_select && $past(rd) && !off
      |=> (off || !o_dq_oe_n) ##1 o_dq_oe_n)
      else $error("dual deselect timing wrong");
   a_desel_off: assert property (s_desel_quiet |=> o_dq_oe_n)
      else $error("drive on after deselect");
   a_write_quiet: assert property (
      wr && o_dq_oe_n && !off && $past(stb || !i_global_write_n) && !$past(rd)
      |=> o_dq_oe_n)
      else $error("write drove the data pins");
endmodule

bind sdsr_sync_burst_sram sdsr_sync_burst_sram_props #(.LANES(LANES)) i_props (
   .i_sys_clk, .i_rst, .o_dq_oe_n, .i_chip_enable_first_n, .i_chip_enable_second,
   .i_chip_enable_third_n, .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n, .i_global_write_n,
   .i_byte_write_enable_n, .i_lane_byte_select_n, .i_out_enable_n, .i_sleep_request,
   .i_flow_through_select, .i_deselect_mode_select);

`default_nettype wire

// ### verif/tb_sdsr_sync_burst_sram.sv
// Self-checking bench: host model drives the memory, bench predicts data.
// Assumes the 36-bit organisation and a 100 MHz clock.
`default_nettype none

module tb_sdsr_sync_burst_sram;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DW = sdsr_pkg::W_X36;
   localparam int LN = DW / sdsr_pkg::LANE_BITS;
   localparam int AW = sdsr_pkg::AW_X36;
   localparam int NOP = 0, RDP = 1, RDC = 2, WRG = 3, WRB = 4, STP = 5, STW = 6, DSL = 7;
   localparam int PWR = 8;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          oe_in_n = 1'b0;
   logic          sleep = 1'b0;
   logic          flow_sel = sdsr_pkg::DEFAULT_FLOW_THROUGH_SELECT;
   logic          order_sel = sdsr_pkg::DEFAULT_BURST_ORDER_SELECT;
   logic          desel_sel = sdsr_pkg::DEFAULT_DESELECT_MODE_SELECT;
   logic [AW-1:0] addr;
   logic [DW-1:0] dq_in, dq_out;
   logic          oe_n, ce1_n, ce2, ce3_n, ps_n, cs_n, step_n, glob_n, bwe_n;
   logic [LN-1:0] bs_n;
   logic [DW-1:0] ref_mem [int]; // Expected array contents
   int            num_errors = 0;
   int            num_checks = 0;

   always #5 clk = ~clk;

   sdsr_host_model #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW)) i_host (.i_sys_clk(clk),
      .o_addr(addr), .o_dq(dq_in), .o_chip_enable_first_n(ce1_n), .o_chip_enable_second(ce2),
      .o_chip_enable_third_n(ce3_n), .o_proc_addr_strobe_n(ps_n), .o_ctrl_addr_strobe_n(cs_n),
      .o_burst_advance_n(step_n), .o_global_write_n(glob_n), .o_byte_write_enable_n(bwe_n),
      .o_lane_byte_select_n(bs_n));

   sdsr_sync_burst_sram #(.DATA_W(DW)) i_sdsr_sync_burst_sram (.i_sys_clk(clk), .i_rst(rst),
      .i_addr(addr), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe_n(oe_n),
      .i_chip_enable_first_n(ce1_n), .i_chip_enable_second(ce2), .i_chip_enable_third_n(ce3_n),
      .i_proc_addr_strobe_n(ps_n), .i_ctrl_addr_strobe_n(cs_n), .i_burst_advance_n(step_n),
      .i_global_write_n(glob_n), .i_byte_write_enable_n(bwe_n), .i_lane_byte_select_n(bs_n),
      .i_out_enable_n(oe_in_n), .i_sleep_request(sleep), .i_flow_through_select(flow_sel),
      .i_burst_order_select(order_sel), .i_deselect_mode_select(desel_sel));

   // Word address of beat k in the current order
   function automatic logic [AW-1:0] bea(input logic [AW-1:0] a, input int k);
      return {a[AW-1:2], order_sel ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
   endfunction

   task automatic chk_d(input logic [DW-1:0] g, input logic [DW-1:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t data %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_b(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %0t drive enable %b expected %b", $time, g, e);
      end
   endtask

   // Four-beat global write burst, then deselect
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      for (int k = 0; k < 4; k++) begin
         i_host.op(k == 0 ? WRG : STW, a, d + DW'(k));
         ref_mem[bea(a, k)] = d + DW'(k);
      end
      i_host.op(DSL);
   endtask

   // Burst read (bt) or back-to-back single reads, checked beat by beat
   task automatic rd(input logic [AW-1:0] a, input bit bt);
      int b;
      for (int j = 0; j < 6; j++) begin
         i_host.op(j == 0 || (!bt && j < 4) ? (bt ? RDC : RDP) : STP, bt ? a : a + AW'(j));
         b = j - 1 - int'(flow_sel);
         if (b >= 0 && b < 4) begin
            chk_b(oe_n, 1'b0);
            chk_d(dq_out, ref_mem[bt ? bea(a, b) : a + AW'(b)]);
         end
      end
      oe_in_n <= 1'b1;
      i_host.op(NOP);
      chk_b(oe_n, 1'b1);
      oe_in_n <= 1'b0;
      i_host.op(DSL);
      i_host.op(NOP);
      i_host.op(DSL);
   endtask

   task automatic close_out;
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk_b(oe_n, 1'b1);
      // Byte lanes, refused proc-strobe write, write during sleep
      wr(64, 36'h0_1234_5678);
      i_host.op(WRB, 64, 36'hf_ffff_ffff, 4'b1010);
      ref_mem[64][8:0] = 9'h1ff;
      ref_mem[64][26:18] = 9'h1ff;
      i_host.op(PWR, 65, 36'h0_0000_0000);
      sleep <= 1'b1;
      i_host.op(WRG, 66, 36'h0_0000_0000);
      chk_b(oe_n, 1'b1);
      sleep <= 1'b0;
      i_host.op(DSL);
      rd(64, 1'b0);
      // Every output mode and burst order
      for (int m = 0; m < 4; m++) begin
         flow_sel <= m[1];
         order_sel <= m[0];
         wr(AW'(16 * m + 1), DW'(m) << 20);
         rd(AW'(16 * m + 1), 1'b1);
      end
      // Single then dual deselect after a pipelined read
      for (int s = 1; s >= 0; s--) begin
         desel_sel <= s[0];
         flow_sel <= 1'b1;
         i_host.op(RDC, 64);
         i_host.op(DSL);
         i_host.op(NOP);
         chk_b(oe_n, s[0]);
         if (s == 0) begin
            chk_d(dq_out, ref_mem[64]);
         end
         i_host.op(NOP);
         chk_b(oe_n, 1'b1);
      end
      close_out();
   end
endmodule

`default_nettype wire
